// ==== bench/charger_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// charger side: decodes the requested operating point
// ****************************************************************
module charger_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // answers seen on the bus
    input wire logic rd_valid_in,
    input wire logic [15:0] rd_data_in,
    input wire logic [7:0] read_code_in,
    // decoded operating point
    output logic cv_source_out,
    output logic cc_source_out
);
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            cv_source_out <= 1'b0;
            cc_source_out <= 1'b0;
        end else if (rd_valid_in && read_code_in == 8'h14) begin
            cv_source_out <= rd_data_in == 16'hFFFF;
        end else if (rd_valid_in && read_code_in == 8'h15) begin
            cc_source_out <= rd_data_in == 16'hFFFF;
        end
    end
endmodule

// ==== bench/gauge_status_sva.sv ====
`timescale 1ns/1ps
// ****************************************************************
// status word and answer checks
// ****************************************************************
module gauge_status_sva #(
    parameter int WORD_W = 16,
    parameter int PCT_W = 8
) (
    // watched ports
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic cmd_valid_in,
    input wire logic cmd_write_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [WORD_W-1:0] cmd_length_in,
    input wire logic charger_off_in,
    input wire logic cv_mode_in,
    input wire logic cc_mode_in,
    input wire logic charging_detected_in,
    input wire logic rd_valid_out,
    input wire logic [WORD_W-1:0] rd_data_out,
    input wire logic flash_wr_out,
    input wire logic [7:0] flash_addr_out,
    input wire logic [WORD_W-1:0] pack_status_word_out,
    input wire logic [WORD_W-1:0] alarm_broadcast_message_out
);
    wire logic hit = cmd_code_in[7:2] == 6'h05;
    wire logic rd = ce_in && cmd_valid_in && !cmd_write_in && hit;
    wire logic wr = ce_in && cmd_valid_in && cmd_write_in && hit;
    wire logic [2:0] err = pack_status_word_out[2:0];
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    a_read_answer_pulse: assert property (rd |=> rd_valid_out)
        else $error("read not answered");
    a_charger_off_zero: assert property (rd && cmd_code_in == 8'h14 && charger_off_in
        && $past(charger_off_in) |=> rd_data_out == 16'h0000) else $error("off not zero");
    a_cv_request_ones: assert property (rd && cmd_code_in == 8'h14 && $past(resetn_in)
        && cv_mode_in && !charger_off_in && $past(cv_mode_in) && !$past(charger_off_in)
        |=> rd_data_out == 16'hFFFF) else $error("cv request wrong");
    a_cc_request_ones: assert property (rd && cmd_code_in == 8'h15 && $past(resetn_in)
        && cc_mode_in && $past(cc_mode_in) |=> rd_data_out == 16'hFFFF)
        else $error("cc request wrong");
    a_broadcast_err_bits: assert property (alarm_broadcast_message_out
        == {pack_status_word_out[15:3], 3'h7}) else $error("broadcast mismatch");
    a_reserved_bits_zero: assert property (pack_status_word_out[13] == 1'b0
        && pack_status_word_out[10] == 1'b0 && pack_status_word_out[3] == 1'b0)
        else $error("reserved bit set");
    a_write_denied_code: assert property (wr && cmd_length_in == 16'h0002
        |-> ##2 err == 3'h4) else $error("write code wrong");
    a_wrong_length_code: assert property (wr && cmd_length_in != 16'h0002
        |-> ##2 err == 3'h6) else $error("length code wrong");
    a_not_charging_flag: assert property (ce_in ##1 ce_in |=> pack_status_word_out[6]
        != $past(charging_detected_in, 2)) else $error("charging flag wrong");
    a_flash_cycle_addr: assert property (flash_wr_out |-> flash_addr_out == 8'h0C)
        else $error("flash address wrong");
endmodule
bind gauge_status_regs gauge_status_sva #(.WORD_W(WORD_W), .PCT_W(PCT_W)) u_sva (
    .clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .cmd_valid_in(cmd_valid_in),
    .cmd_write_in(cmd_write_in), .cmd_code_in(cmd_code_in), .cmd_length_in(cmd_length_in),
    .charger_off_in(charger_off_in), .cv_mode_in(cv_mode_in), .cc_mode_in(cc_mode_in),
    .charging_detected_in(charging_detected_in), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .flash_wr_out(flash_wr_out), .flash_addr_out(flash_addr_out),
    .pack_status_word_out(pack_status_word_out),
    .alarm_broadcast_message_out(alarm_broadcast_message_out));

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
// ****************************************************************
// gauge status bench
// ****************************************************************
module testbench;
    logic clk_in = 1'b0;
    logic resetn_in, ce_in, cmd_valid_in, cmd_write_in, ext_error_valid_in, charger_off_in;
    logic cv_mode_in, cc_mode_in, charging_detected_in, overcharge_detected_in, init_ok;
    logic param_out_of_range_in, primary_termination_in, discharge_mah_tick_in, capacity_mode_in;
    logic cell_undervoltage_flag_in, flash_load_valid_in, flash_load_improper_in;
    logic [2:0] ext_error_code_in;
    logic [7:0] cmd_code_in, relative_charge_percent_in, fully_charged_clear_pct_in;
    logic [7:0] battery_low_pct_in, flash_addr_out, code_r;
    logic [15:0] cmd_length_in, charge_current_target_in, charge_voltage_target_in, temperature_in;
    logic [15:0] max_temperature_in, remaining_charge_in, remaining_energy_in, time_alarm_level_in;
    logic [15:0] capacity_alarm_level_in, time_to_empty_charge_in, time_to_empty_energy_in;
    logic [15:0] pack_voltage_in, terminate_voltage_in, cell_voltage_in, cycle_threshold_in;
    logic [15:0] second_end_discharge_threshold_in, flash_cycle_count_in, last_wr;
    logic [15:0] rd_data_out, flash_data_out, pack_status_word_out, alarm_broadcast_message_out;
    logic signed [15:0] current_in, overload_current_in;
    logic rd_valid_out, cmd_hit_out, flash_wr_out, cv_src, cc_src;
    int bad_count = 0, compares = 0, cycles = 0, nwr = 0, i;
    gauge_status_regs DUT (.*);
    charger_model partner (.clk_in(clk_in), .resetn_in(resetn_in), .rd_valid_in(rd_valid_out),
        .rd_data_in(rd_data_out), .read_code_in(code_r), .cv_source_out(cv_src),
        .cc_source_out(cc_src));
    initial forever #12.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (flash_wr_out === 1'b1) begin
            nwr++;
            last_wr = flash_data_out;
        end
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    task end_of_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [15:0] r16();
        return 16'($urandom);
    endfunction
    // a value that never equals v, so hold-on-equal alarms stay predictable
    function automatic logic [15:0] above(logic [15:0] v);
        return v + 16'(1 + $urandom % 65534);
    endfunction
    function automatic logic [15:0] exp_status(logic [2:0] err);
        logic [15:0] s;
        s = {13'h0000, err};
        s[14] = charging_detected_in && param_out_of_range_in;
        s[12] = temperature_in >= max_temperature_in;
        s[11] = remaining_charge_in == 0 || pack_voltage_in <= terminate_voltage_in
            || cell_undervoltage_flag_in;
        s[9] = (capacity_mode_in ? remaining_energy_in : remaining_charge_in)
            < capacity_alarm_level_in;
        s[8] = (capacity_mode_in ? time_to_empty_energy_in : time_to_empty_charge_in)
            < time_alarm_level_in;
        s[7] = init_ok;
        s[6] = !charging_detected_in;
        return s;
    endfunction
    task automatic cmd(logic [7:0] c, logic w, logic [15:0] len);
        @(negedge clk_in);
        {cmd_code_in, cmd_write_in, cmd_length_in, cmd_valid_in, code_r} = {c, w, len, 1'b1, c};
        @(negedge clk_in);
        cmd_valid_in = 1'b0;
    endtask
    task automatic rd(logic [7:0] c, logic [15:0] exp);
        cmd(c, 1'b0, 16'h0002);
        chk("answer strobe", 16'h0003, {14'h0000, cmd_hit_out, rd_valid_out});
        chk($sformatf("read %h", c), exp, rd_data_out);
    endtask
    task automatic shake;
        {temperature_in, max_temperature_in, pack_voltage_in, terminate_voltage_in} = {r16(), r16(),
            r16(), r16()};
        if (r16() < 16'h2000) temperature_in = max_temperature_in;
        if (r16() < 16'h2000) pack_voltage_in = terminate_voltage_in;
        {cell_voltage_in, current_in, overload_current_in} = {r16(), r16(), r16()};
        {capacity_alarm_level_in, time_alarm_level_in} = {r16(), r16()};
        remaining_charge_in = above(capacity_alarm_level_in);
        remaining_energy_in = above(capacity_alarm_level_in);
        time_to_empty_charge_in = above(time_alarm_level_in);
        time_to_empty_energy_in = above(time_alarm_level_in);
        {capacity_mode_in, cell_undervoltage_flag_in, charging_detected_in} = 3'($urandom);
        param_out_of_range_in = 1'($urandom);
        relative_charge_percent_in = 8'(20 + $urandom % 80);
    endtask
    initial begin
        void'($urandom(59));
        shake();
        {resetn_in, cmd_valid_in, cmd_write_in, cmd_code_in, cmd_length_in, ext_error_valid_in,
            ext_error_code_in, charger_off_in, cv_mode_in, cc_mode_in, overcharge_detected_in,
            primary_termination_in, discharge_mah_tick_in, flash_load_valid_in, code_r,
            flash_load_improper_in, flash_cycle_count_in, cycle_threshold_in, init_ok,
            fully_charged_clear_pct_in, battery_low_pct_in, second_end_discharge_threshold_in} = '0;
        {ce_in, charge_current_target_in, charge_voltage_target_in} = {1'b1, r16(), r16()};
        repeat (16) @(negedge clk_in);
        chk("status at reset", 16'h0040, pack_status_word_out);
        chk("broadcast at reset", 16'h0047, alarm_broadcast_message_out);
        resetn_in = 1'b1;
        flash_cycle_count_in = 16'hFFFD;
        for (i = 0; i < 3; i++) begin
            @(negedge clk_in);
            {flash_load_improper_in, flash_load_valid_in} = (i == 1) ? 2'b10 : 2'b01;
            @(negedge clk_in);
            {flash_load_improper_in, flash_load_valid_in, init_ok} = {2'b00, i != 1};
            rd(8'h16, exp_status(3'h0));
        end
        for (i = 0; i < 16; i++) begin
            {charger_off_in, cv_mode_in, cc_mode_in} = 3'(i);
            {charge_current_target_in, charge_voltage_target_in} = {r16() >> 1, r16() >> 1};
            rd(8'h14, charger_off_in ? 16'h0000 : cv_mode_in ? 16'hFFFF
                : charge_current_target_in);
            rd(8'h15, cc_mode_in ? 16'hFFFF : charge_voltage_target_in);
            @(negedge clk_in);
            chk("charger cv", {15'h0000, cv_mode_in && !charger_off_in}, {15'h0000, cv_src});
            chk("charger cc", {15'h0000, cc_mode_in}, {15'h0000, cc_src});
        end
        for (i = 0; i < 8; i++) begin
            cmd(8'h14 + 8'(i / 2), 1'b1, i[0] ? 16'(i) : 16'h0002);
            rd(8'h16, exp_status(i[0] ? 3'h6 : 3'h4));
            @(negedge clk_in);
            {ext_error_valid_in, ext_error_code_in} = {1'b1, i[2:0]};
            @(negedge clk_in);
            ext_error_valid_in = 1'b0;
            rd(8'h16, exp_status(i[2:0]));
        end
        cmd(8'h13, 1'b1, 16'h0001);
        chk("foreign code", 16'h0000, {14'h0000, cmd_hit_out, rd_valid_out});
        repeat (40) begin
            shake();
            rd(8'h16, exp_status(3'h0));
        end
        {cycle_threshold_in, charging_detected_in} = {16'h0002, 1'b0};
        rd(8'h17, 16'hFFFD);
        for (i = 1; i < 4; i++) begin
            repeat (4) @(negedge clk_in) discharge_mah_tick_in = ~discharge_mah_tick_in;
            repeat (2) @(negedge clk_in);
            rd(8'h17, i < 3 ? 16'hFFFD + 16'(i) : 16'hFFFF);
            if (i < 3) chk("flash image", 16'hFFFD + 16'(i), last_wr);
            if (i < 3) chk("flash writes", 16'(i), 16'(nwr));
        end
        {charging_detected_in, overcharge_detected_in, battery_low_pct_in} = {2'b11, 8'h14};
        relative_charge_percent_in = 8'h13;
        @(negedge clk_in);
        {charging_detected_in, overcharge_detected_in, battery_low_pct_in} = '0;
        rd(8'h16, exp_status(3'h0) | 16'h8030);
        repeat (4) @(negedge clk_in) discharge_mah_tick_in = ~discharge_mah_tick_in;
        relative_charge_percent_in = 8'h14;
        @(negedge clk_in);
        rd(8'h16, exp_status(3'h0) | 16'h0020);
        end_of_test();
    end
endmodule

// ==== core/gauge_status_pkg.sv ====
package gauge_status_pkg;

    // ****************************************************************
    // command codes
    // ****************************************************************
    localparam logic [7:0] CMD_CHARGE_CURRENT = 8'h14;
    localparam logic [7:0] CMD_CHARGE_VOLTAGE = 8'h15;
    localparam logic [7:0] CMD_PACK_STATUS = 8'h16;
    localparam logic [7:0] CMD_CYCLE_COUNT = 8'h17;

    // ****************************************************************
    // status word field positions
    // ****************************************************************
    localparam int BIT_OVER_CHARGED = 15;
    localparam int BIT_STOP_CHARGE = 14;
    localparam int BIT_OVER_TEMP = 12;
    localparam int BIT_STOP_DISCHARGE = 11;
    localparam int BIT_LOW_CAPACITY = 9;
    localparam int BIT_LOW_TIME = 8;
    localparam int BIT_INITIALIZED = 7;
    localparam int BIT_NOT_CHARGING = 6;
    localparam int BIT_FULLY_CHARGED = 5;
    localparam int BIT_FULLY_DISCHARGED = 4;
    localparam int ERR_LSB = 0;
    localparam int ERR_WIDTH = 3;

    // ****************************************************************
    // error codes
    // ****************************************************************
    typedef enum logic [2:0] {
        ERR_OK = 3'h0,
        ERR_BUSY = 3'h1,
        ERR_RESERVED_CMD = 3'h2,
        ERR_UNSUPPORTED_CMD = 3'h3,
        ERR_WRITE_PROTECTED = 3'h4,
        ERR_OVER_UNDER_FLOW = 3'h5,
        ERR_WRONG_LENGTH = 3'h6,
        ERR_UNKNOWN = 3'h7
    } error_code_t;

    // ****************************************************************
    // values, limits and reset values
    // ****************************************************************
    localparam logic [15:0] CHARGER_OFF_VALUE = 16'h0000;
    localparam logic [15:0] BEYOND_RANGE_VALUE = 16'hFFFF;
    localparam logic [15:0] CYCLE_SATURATE = 16'hFFFF;
    localparam logic [15:0] CYCLE_RESET = 16'h0000;
    localparam logic [7:0] DISCHARGE_CLEAR_MAH = 8'h02;
    localparam logic [7:0] FULLY_DISCHARGED_CLEAR_PCT = 8'h14;
    localparam logic [7:0] FLASH_CYCLE_ADDR = 8'h0C;
    localparam logic [7:0] FLASH_FULL_CLEAR_ADDR = 8'h47;
    localparam logic [7:0] FLASH_CYCLE_THRESH_ADDR = 8'h37;
    localparam logic [15:0] STATUS_RESET = 16'h0040;
    localparam logic [15:0] WORD_LENGTH_BYTES = 16'h0002;

endpackage

// ==== core/gauge_status_regs.sv ====
`timescale 1ns/1ps
module gauge_status_regs #(
    parameter int WORD_W = 16,
    parameter int PCT_W = 8
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    // command port from the bus engine
    input wire logic cmd_valid_in,
    input wire logic cmd_write_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [WORD_W-1:0] cmd_length_in,
    input wire logic ext_error_valid_in,
    input wire logic [2:0] ext_error_code_in,
    output logic rd_valid_out,
    output logic [WORD_W-1:0] rd_data_out,
    output logic cmd_hit_out,
    // charge request from the gauge algorithm
    input wire logic [WORD_W-1:0] charge_current_target_in,
    input wire logic [WORD_W-1:0] charge_voltage_target_in,
    input wire logic charger_off_in,
    input wire logic cv_mode_in,
    input wire logic cc_mode_in,
    // measurements and thresholds
    input wire logic charging_detected_in,
    input wire logic overcharge_detected_in,
    input wire logic param_out_of_range_in,
    input wire logic primary_termination_in,
    input wire logic discharge_mah_tick_in,
    input wire logic [WORD_W-1:0] temperature_in,
    input wire logic [WORD_W-1:0] max_temperature_in,
    input wire logic capacity_mode_in,
    input wire logic [WORD_W-1:0] remaining_charge_in,
    input wire logic [WORD_W-1:0] remaining_energy_in,
    input wire logic [WORD_W-1:0] capacity_alarm_level_in,
    input wire logic [WORD_W-1:0] time_to_empty_charge_in,
    input wire logic [WORD_W-1:0] time_to_empty_energy_in,
    input wire logic [WORD_W-1:0] time_alarm_level_in,
    input wire logic [WORD_W-1:0] pack_voltage_in,
    input wire logic [WORD_W-1:0] terminate_voltage_in,
    input wire logic cell_undervoltage_flag_in,
    input wire logic [WORD_W-1:0] cell_voltage_in,
    input wire logic [WORD_W-1:0] second_end_discharge_threshold_in,
    input wire logic signed [WORD_W-1:0] current_in,
    input wire logic signed [WORD_W-1:0] overload_current_in,
    input wire logic [PCT_W-1:0] relative_charge_percent_in,
    input wire logic [PCT_W-1:0] fully_charged_clear_pct_in,
    input wire logic [PCT_W-1:0] battery_low_pct_in,
    // data flash load and cycle count store
    input wire logic flash_load_valid_in,
    input wire logic flash_load_improper_in,
    input wire logic [WORD_W-1:0] flash_cycle_count_in,
    input wire logic [WORD_W-1:0] cycle_threshold_in,
    output logic flash_wr_out,
    output logic [7:0] flash_addr_out,
    output logic [WORD_W-1:0] flash_data_out,
    // status outputs
    output logic [WORD_W-1:0] pack_status_word_out,
    output logic [WORD_W-1:0] alarm_broadcast_message_out
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [WORD_W-1:0] charge_current_request;
    logic [WORD_W-1:0] charge_voltage_request;
    logic [WORD_W-1:0] wear_cycle_counter;
    logic [WORD_W-1:0] cycle_accum;
    logic [7:0] discharge_accum;
    logic over_charged;
    logic stop_charge;
    logic over_temp;
    logic stop_discharge;
    logic low_capacity;
    logic low_time;
    logic initialized;
    logic not_charging;
    logic fully_charged;
    logic fully_discharged;
    gauge_status_pkg::error_code_t error_code;

    function automatic logic [WORD_W-1:0] sat_inc(input logic [WORD_W-1:0] v);
        sat_inc = (v == gauge_status_pkg::CYCLE_SATURATE) ? v : v + 1'b1;
    endfunction

    // ****************************************************************
    // charge request values
    // ****************************************************************
    logic [WORD_W-1:0] next_charge_current;
    logic [WORD_W-1:0] next_charge_voltage;

    assign next_charge_current = charger_off_in ? gauge_status_pkg::CHARGER_OFF_VALUE :
                                 cv_mode_in ? gauge_status_pkg::BEYOND_RANGE_VALUE :
                                 charge_current_target_in;
    assign next_charge_voltage = cc_mode_in ? gauge_status_pkg::BEYOND_RANGE_VALUE :
                                 charge_voltage_target_in;

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            charge_current_request <= gauge_status_pkg::CHARGER_OFF_VALUE;
            charge_voltage_request <= gauge_status_pkg::CHARGER_OFF_VALUE;
        end else if (ce_in) begin
            charge_current_request <= next_charge_current;
            charge_voltage_request <= next_charge_voltage;
        end
    end

    // ****************************************************************
    // alarm conditions
    // ****************************************************************
    logic discharge_done;
    logic oc_set;
    logic oc_clr;
    logic sc_set;
    logic ot_set;
    logic sd_set;
    logic [WORD_W-1:0] capacity_sel;
    logic [WORD_W-1:0] time_sel;
    logic lc_set;
    logic lc_clr;
    logic lt_set;
    logic lt_clr;
    logic fc_set;
    logic fc_clr;
    logic low_voltage;
    logic fd_set;
    logic fd_clr;

    assign discharge_done = (discharge_accum >= gauge_status_pkg::DISCHARGE_CLEAR_MAH);
    assign oc_set = charging_detected_in && overcharge_detected_in;
    assign oc_clr = !charging_detected_in && discharge_done;
    assign sc_set = charging_detected_in && (param_out_of_range_in || primary_termination_in);
    assign ot_set = (temperature_in >= max_temperature_in);
    assign sd_set = (remaining_charge_in == '0) ||
                    (pack_voltage_in <= terminate_voltage_in) ||
                    cell_undervoltage_flag_in;
    assign capacity_sel = capacity_mode_in ? remaining_energy_in : remaining_charge_in;
    assign time_sel = capacity_mode_in ? time_to_empty_energy_in : time_to_empty_charge_in;
    assign lc_set = (capacity_sel < capacity_alarm_level_in);
    assign lc_clr = (capacity_alarm_level_in < capacity_sel);
    assign lt_set = (time_sel < time_alarm_level_in);
    assign lt_clr = (time_alarm_level_in < time_sel);
    assign fc_set = primary_termination_in || overcharge_detected_in;
    assign fc_clr = (relative_charge_percent_in < fully_charged_clear_pct_in);
    assign low_voltage = (pack_voltage_in < second_end_discharge_threshold_in) ||
                         (cell_voltage_in < second_end_discharge_threshold_in);
    assign fd_set = (low_voltage && (current_in < overload_current_in)) ||
                    (relative_charge_percent_in < battery_low_pct_in);
    assign fd_clr = (relative_charge_percent_in >= gauge_status_pkg::FULLY_DISCHARGED_CLEAR_PCT);

    // continuous discharge after charging stops, for the overcharge clear
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            discharge_accum <= '0;
        end else if (ce_in) begin
            if (charging_detected_in) begin
                discharge_accum <= '0;
            end else if (discharge_mah_tick_in && !discharge_done) begin
                discharge_accum <= discharge_accum + 8'h01;
            end
        end
    end

    // set wins over clear on over_charged, low_capacity, low_time, fully_charged and fully_discharged
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            over_charged <= 1'b0;
            stop_charge <= 1'b0;
            over_temp <= 1'b0;
            stop_discharge <= 1'b0;
            low_capacity <= 1'b0;
            low_time <= 1'b0;
            fully_charged <= 1'b0;
            fully_discharged <= 1'b0;
            not_charging <= gauge_status_pkg::STATUS_RESET[gauge_status_pkg::BIT_NOT_CHARGING];
        end else if (ce_in) begin
            over_charged <= oc_set | (over_charged & ~oc_clr);
            stop_charge <= sc_set;
            over_temp <= ot_set;
            stop_discharge <= sd_set;
            low_capacity <= lc_set | (low_capacity & ~lc_clr);
            low_time <= lt_set | (low_time & ~lt_clr);
            fully_charged <= fc_set | (fully_charged & ~fc_clr);
            fully_discharged <= fd_set | (fully_discharged & ~fd_clr);
            not_charging <= ~charging_detected_in;
        end
    end

    // ****************************************************************
    // initialized flag
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            initialized <= 1'b0;
        end else if (ce_in) begin
            if (flash_load_valid_in) begin
                initialized <= 1'b1;
            end else if (flash_load_improper_in) begin
                initialized <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // cycle counter with flash mirror
    // ****************************************************************
    logic cycle_step;
    logic [WORD_W-1:0] next_cycle_count;

    assign cycle_step = discharge_mah_tick_in && (cycle_threshold_in != '0) &&
                        ((cycle_accum + 1'b1) >= cycle_threshold_in);
    assign next_cycle_count = sat_inc(wear_cycle_counter);

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            wear_cycle_counter <= gauge_status_pkg::CYCLE_RESET;
            cycle_accum <= '0;
            flash_wr_out <= 1'b0;
            flash_data_out <= '0;
        end else if (ce_in) begin
            flash_wr_out <= 1'b0;
            if (flash_load_valid_in) begin
                wear_cycle_counter <= flash_cycle_count_in;
                cycle_accum <= '0;
            end else if (cycle_step) begin
                cycle_accum <= '0;
                wear_cycle_counter <= next_cycle_count;
                flash_wr_out <= 1'b1;
                flash_data_out <= next_cycle_count;
            end else if (discharge_mah_tick_in) begin
                cycle_accum <= cycle_accum + 1'b1;
            end
        end
    end

    assign flash_addr_out = gauge_status_pkg::FLASH_CYCLE_ADDR;

    // ****************************************************************
    // command decode and error code
    // ****************************************************************
    logic hit;
    logic bad_length;
    logic [WORD_W-1:0] status_word;
    logic [WORD_W-1:0] read_mux;

    assign hit = (cmd_code_in >= gauge_status_pkg::CMD_CHARGE_CURRENT) &&
                 (cmd_code_in <= gauge_status_pkg::CMD_CYCLE_COUNT);
    assign cmd_hit_out = hit;
    assign bad_length = (cmd_length_in != gauge_status_pkg::WORD_LENGTH_BYTES);

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            error_code <= gauge_status_pkg::ERR_OK;
        end else if (ce_in) begin
            if (cmd_valid_in && hit) begin
                if (cmd_write_in && bad_length) begin
                    error_code <= gauge_status_pkg::ERR_WRONG_LENGTH;
                end else if (cmd_write_in) begin
                    error_code <= gauge_status_pkg::ERR_WRITE_PROTECTED;
                end else begin
                    error_code <= gauge_status_pkg::ERR_OK;
                end
            end else if (ext_error_valid_in) begin
                error_code <= gauge_status_pkg::error_code_t'(ext_error_code_in);
            end
        end
    end

    // reserved bits stay zero
    always_comb begin
        status_word = '0;
        status_word[gauge_status_pkg::BIT_OVER_CHARGED] = over_charged;
        status_word[gauge_status_pkg::BIT_STOP_CHARGE] = stop_charge;
        status_word[gauge_status_pkg::BIT_OVER_TEMP] = over_temp;
        status_word[gauge_status_pkg::BIT_STOP_DISCHARGE] = stop_discharge;
        status_word[gauge_status_pkg::BIT_LOW_CAPACITY] = low_capacity;
        status_word[gauge_status_pkg::BIT_LOW_TIME] = low_time;
        status_word[gauge_status_pkg::BIT_INITIALIZED] = initialized;
        status_word[gauge_status_pkg::BIT_NOT_CHARGING] = not_charging;
        status_word[gauge_status_pkg::BIT_FULLY_CHARGED] = fully_charged;
        status_word[gauge_status_pkg::BIT_FULLY_DISCHARGED] = fully_discharged;
        status_word[gauge_status_pkg::ERR_LSB +: gauge_status_pkg::ERR_WIDTH] = error_code;
    end

    assign read_mux = (cmd_code_in == gauge_status_pkg::CMD_CHARGE_CURRENT) ? charge_current_request :
                      (cmd_code_in == gauge_status_pkg::CMD_CHARGE_VOLTAGE) ? charge_voltage_request :
                      (cmd_code_in == gauge_status_pkg::CMD_PACK_STATUS) ? status_word :
                      wear_cycle_counter;

    // ****************************************************************
    // read answer and status outputs
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out <= '0;
            pack_status_word_out <= gauge_status_pkg::STATUS_RESET;
            alarm_broadcast_message_out <= gauge_status_pkg::STATUS_RESET | 16'h0007;
        end else if (ce_in) begin
            rd_valid_out <= cmd_valid_in && hit && !cmd_write_in;
            if (cmd_valid_in && hit && !cmd_write_in) begin
                rd_data_out <= read_mux;
            end
            pack_status_word_out <= status_word;
            alarm_broadcast_message_out <= status_word | 16'h0007;
        end
    end

endmodule
